// ---- nvm_write_status_protection.sv ----
// Status, write-command sequencing and protection logic of the flash and emulated EEPROM.
// Assumes a byte-wide core bus with one-cycle read and write strobes and a macro that reports results.
//
// Behaviour
// - Reads of a memory under write return 0xff.
// - Write error flag sets on any failed write, holds until software clears.
// - Seven read-only sector status bits; bits 5 to 0 mirror the six busy sectors, bit 6 reads zero.
// - Sector bit meaning follows error, busy and suspend combination.
// - Erase fail flag sets on erase failure; causes clear with write error.
// - Program fail flag sets when a cell cannot be programmed.
// - Flash overwrite of zero to one sets flag, except protection programming.
// - EEPROM swap failure sets flag, skips old-sector erase, keeps old data.
// - Clearing selection before start cancels and discards latched pairs.
// - Page operations keep only the last latched page address.
// - Access protections forced active in reset, then loaded from test area.
// - Set-protection accepted only when fetched outside flash and test area.
// - Writes to the test area range are always ignored.
// - Protection registers one-time programmable; locked after access lock programmed.
// - Flash lock blocks operands unless fetched from test area or flash.
// - Test lock blocks test, one-time and protection space unless fetched there.
// - EEPROM lock blocks unless fetched from test area, flash or EEPROM.
// - External lock blocks internal spaces for externally fetched code.
// - Password mismatch programs one attempt bit, 2 then 1 then 0; test modes ignore them.
// - First password write programs test mode disable to zero.
// - Matching password programs password-ok bit to zero.
`timescale 1ns/10ps
module nvm_write_status_protection #(
    parameter int PAIRS = nvm_pkg::MAX_PAIRS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Core bus
    input wire logic [nvm_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire nvm_pkg::fetch_src_t fetch_src,
    output logic [7:0] bus_rdata,
    // Array read data and protection image from the test area
    input wire logic [7:0] array_rdata,
    input wire logic init_load,
    input wire logic [7:0] init_access_prot,
    input wire logic [7:0] init_write_prot,
    input wire logic [7:0] init_pwd0,
    input wire logic [7:0] init_pwd1,
    // Macro status and results
    input wire logic flash_busy,
    input wire logic eeprom_busy,
    input wire logic erase_suspend,
    input wire logic [5:0] busy_sectors,
    input wire logic op_done,
    input wire logic erase_fail,
    input wire logic program_fail,
    input wire logic overwrite_fail,
    input wire logic swap_fail,
    // Latched operation towards the macro
    output logic flash_start,
    output logic eeprom_start,
    output logic skip_old_erase,
    output logic [nvm_pkg::ADDR_W-1:0] page_addr,
    output logic [4:0] pair_count,
    output logic [7:0] access_prot,
    output logic [7:0] write_prot,
    output logic test_modes_enabled
);
    import nvm_pkg::*;

    logic [7:0] flash_ctrl_ff, eeprom_ctrl_ff;
    logic [7:0] access_prot_ff, write_prot_ff, pwd0_ff, pwd1_ff;
    logic pwd_set_ff;
    logic write_error_ff, erase_fail_ff, program_fail_ff, swap_ff;
    logic [SECTOR_W-1:0] sector_ff;
    logic [7:0] rdata_ff;
    logic [ADDR_W-1:0] page_ff;
    logic [4:0] count_ff;
    logic [7:0] pair_addr_ff [PAIRS];
    logic [7:0] pair_data_ff [PAIRS];
    logic [7:0] pwd_try0_ff, pwd_try1_ff;
    logic pwd_hit0_ff, pwd_hit1_ff;
    logic flash_start_ff, eeprom_start_ff, skip_ff;

    nvm_guard_if gif();
    assign gif.addr = bus_addr;
    assign gif.src = fetch_src;
    assign gif.access_prot = access_prot_ff;

    nvm_access_guard u_guard (
        .g(gif.guard)
    );

    logic hit_ctrl, in_test, is_prot_reg, protect_locked, wr_ok, op_mem_busy;
    logic flash_sel, eeprom_sel, prot_sel;
    logic err_event, clear_error;

    // Register hits and write gating
    assign hit_ctrl = bus_addr == STATUS_SECTOR_ADDR || bus_addr == STATUS_CAUSE_ADDR ||
        bus_addr == FLASH_CTRL_ADDR || bus_addr == EEPROM_CTRL_ADDR;
    assign in_test = bus_addr >= TEST_AREA_LO && bus_addr <= TEST_AREA_HI;
    assign is_prot_reg = bus_addr >= ACCESS_PROTECT_ADDR && bus_addr <= PASSWORD1_ADDR;
    assign protect_locked = !access_prot_ff[FLASH_LOCK_BIT] || !access_prot_ff[TEST_LOCK_BIT];
    assign op_mem_busy = (flash_busy && gif.space == SP_FLASH) ||
        (eeprom_busy && gif.space == SP_EEPROM);
    assign wr_ok = bus_wr && !gif.blocked && !in_test && !op_mem_busy;
    assign flash_sel = flash_ctrl_ff[FLASH_PAGE_BIT];
    assign prot_sel = flash_ctrl_ff[FLASH_PROT_BIT];
    assign eeprom_sel = eeprom_ctrl_ff[EEPROM_PAGE_BIT];
    assign err_event = erase_fail || program_fail || overwrite_fail || swap_fail;
    assign clear_error = bus_wr && bus_addr == STATUS_SECTOR_ADDR && !bus_wdata[WRITE_ERROR_BIT];

    // Control registers; clearing a selection before start cancels the load
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_ctrl_ff <= ZERO_BYTE;
            eeprom_ctrl_ff <= ZERO_BYTE;
        end else begin
            if (bus_wr && bus_addr == FLASH_CTRL_ADDR)
                flash_ctrl_ff <= bus_wdata;
            else if (op_done)
                flash_ctrl_ff <= ZERO_BYTE;
            if (bus_wr && bus_addr == EEPROM_CTRL_ADDR)
                eeprom_ctrl_ff <= bus_wdata;
            else if (op_done)
                eeprom_ctrl_ff <= ZERO_BYTE;
        end
    end

    // Start pulses; set-protection refused when fetched from flash or test area
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_start_ff <= 1'b0;
            eeprom_start_ff <= 1'b0;
        end else begin
            flash_start_ff <= bus_wr && bus_addr == FLASH_CTRL_ADDR && bus_wdata[START_BIT] &&
                !flash_ctrl_ff[START_BIT] && !(prot_sel && (fetch_src == SRC_FLASH ||
                fetch_src == SRC_TEST || fetch_src == SRC_OTP));
            eeprom_start_ff <= bus_wr && bus_addr == EEPROM_CTRL_ADDR && bus_wdata[START_BIT] &&
                !eeprom_ctrl_ff[START_BIT];
        end
    end

    // Address and data pair latch; only the last page address is kept
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            page_ff <= '0;
            count_ff <= '0;
            for (int i = 0; i < PAIRS; i++) begin
                pair_addr_ff[i] <= ZERO_BYTE;
                pair_data_ff[i] <= ZERO_BYTE;
            end
        end else if ((bus_wr && bus_addr == FLASH_CTRL_ADDR && !bus_wdata[FLASH_PAGE_BIT] &&
                      !bus_wdata[FLASH_PROT_BIT] && !flash_ctrl_ff[START_BIT]) ||
                     (bus_wr && bus_addr == EEPROM_CTRL_ADDR && !bus_wdata[EEPROM_PAGE_BIT] &&
                      !eeprom_ctrl_ff[START_BIT]) || op_done) begin
            count_ff <= '0;
            page_ff <= '0;
        end else if (wr_ok && !hit_ctrl && (flash_sel || eeprom_sel || prot_sel) &&
                     int'(count_ff) < PAIRS) begin
            page_ff <= {bus_addr[ADDR_W-1:PAGE_LSB_W], {PAGE_LSB_W{1'b0}}};
            pair_addr_ff[count_ff[3:0]] <= {4'h0, bus_addr[PAGE_LSB_W-1:0]};
            pair_data_ff[count_ff[3:0]] <= bus_wdata;
            count_ff <= count_ff + 5'h01;
        end
    end

    // Error flags; a new event wins over a software clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            write_error_ff <= 1'b0;
            erase_fail_ff <= 1'b0;
            program_fail_ff <= 1'b0;
            swap_ff <= 1'b0;
            skip_ff <= 1'b0;
        end else begin
            write_error_ff <= err_event || (write_error_ff && !clear_error);
            erase_fail_ff <= erase_fail || (erase_fail_ff && !clear_error);
            program_fail_ff <= program_fail || (program_fail_ff && !clear_error);
            swap_ff <= (overwrite_fail && !prot_sel) || swap_fail || (swap_ff && !clear_error);
            skip_ff <= swap_fail || (skip_ff && !eeprom_start_ff);
        end
    end

    // Sector status: six busy sectors load bits 5 to 0, bit 6 stays zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            sector_ff <= '0;
        else if (flash_busy || eeprom_busy || erase_suspend || err_event)
            sector_ff <= {1'b0, busy_sectors};
        else if (!write_error_ff)
            sector_ff <= '0;
    end

    // Protection image: access protections forced active in reset, loaded from test area, one-time programmable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            access_prot_ff <= ZERO_BYTE;
            write_prot_ff <= ZERO_BYTE;
            pwd0_ff <= PROTECT_RESET;
            pwd1_ff <= PROTECT_RESET;
            pwd_set_ff <= 1'b0;
        end else if (init_load) begin
            access_prot_ff <= init_access_prot;
            write_prot_ff <= init_write_prot;
            pwd0_ff <= init_pwd0;
            pwd1_ff <= init_pwd1;
            pwd_set_ff <= !init_write_prot[TEST_MODE_DISABLE_BIT];
        end else if (flash_start_ff && prot_sel && !protect_locked) begin
            for (int i = 0; i < PAIRS; i++) begin
                if (i < int'(count_ff) &&
                    page_ff == {ACCESS_PROTECT_ADDR[ADDR_W-1:PAGE_LSB_W], {PAGE_LSB_W{1'b0}}}) begin
                    case (pair_addr_ff[i][1:0])
                        2'b00: access_prot_ff <= access_prot_ff & pair_data_ff[i];
                        2'b01: write_prot_ff <= write_prot_ff & pair_data_ff[i];
                        default: ;
                    endcase
                end
            end
            if (!pwd_set_ff && (pwd_hit0_ff || pwd_hit1_ff)) begin
                pwd0_ff <= pwd_try0_ff;
                pwd1_ff <= pwd_try1_ff;
                pwd_set_ff <= 1'b1;
                write_prot_ff[TEST_MODE_DISABLE_BIT] <= 1'b0;
            end else if (pwd_set_ff && pwd_hit0_ff && pwd_hit1_ff) begin
                if (pwd_try0_ff == pwd0_ff && pwd_try1_ff == pwd1_ff)
                    write_prot_ff[PASSWORD_OK_BIT_BIT] <= 1'b0;
                else if (access_prot_ff[2])
                    access_prot_ff[2] <= 1'b0;
                else if (access_prot_ff[1])
                    access_prot_ff[1] <= 1'b0;
                else
                    access_prot_ff[0] <= 1'b0;
            end
        end
    end

    // Password candidates gathered as set-protection pairs are loaded
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwd_try0_ff <= PROTECT_RESET;
            pwd_try1_ff <= PROTECT_RESET;
            pwd_hit0_ff <= 1'b0;
            pwd_hit1_ff <= 1'b0;
        end else if (op_done || flash_start_ff) begin
            pwd_hit0_ff <= 1'b0;
            pwd_hit1_ff <= 1'b0;
        end else if (bus_wr && prot_sel && bus_addr == PASSWORD0_ADDR) begin
            pwd_try0_ff <= bus_wdata;
            pwd_hit0_ff <= 1'b1;
        end else if (bus_wr && prot_sel && bus_addr == PASSWORD1_ADDR) begin
            pwd_try1_ff <= bus_wdata;
            pwd_hit1_ff <= 1'b1;
        end
    end

    // Read mux: busy memory or blocked operand reads as blank
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            rdata_ff <= ZERO_BYTE;
        else if (bus_rd) begin
            if (op_mem_busy)
                rdata_ff <= BLANK_BYTE;
            else if (gif.blocked)
                rdata_ff <= BLANK_BYTE;
            else if (bus_addr == STATUS_SECTOR_ADDR)
                rdata_ff <= {write_error_ff, sector_ff};
            else if (bus_addr == STATUS_CAUSE_ADDR)
                rdata_ff <= {erase_fail_ff, program_fail_ff, swap_ff, 5'h00};
            else if (bus_addr == FLASH_CTRL_ADDR)
                rdata_ff <= {flash_ctrl_ff[7:1], flash_busy};
            else if (bus_addr == EEPROM_CTRL_ADDR)
                rdata_ff <= {eeprom_ctrl_ff[7:1], eeprom_busy};
            else if (bus_addr == ACCESS_PROTECT_ADDR)
                rdata_ff <= {1'b1, access_prot_ff[6:0]};
            else if (bus_addr == WRITE_PROTECT_ADDR)
                rdata_ff <= write_prot_ff;
            else if (is_prot_reg)
                rdata_ff <= BLANK_BYTE;
            else
                rdata_ff <= array_rdata;
        end
    end

    // Registered outputs; test_modes_enabled decoded from write_prot_ff
    assign bus_rdata = rdata_ff;
    assign flash_start = flash_start_ff;
    assign eeprom_start = eeprom_start_ff;
    assign skip_old_erase = skip_ff;
    assign page_addr = page_ff;
    assign pair_count = count_ff;
    assign access_prot = access_prot_ff;
    assign write_prot = write_prot_ff;
    assign test_modes_enabled = write_prot_ff[TEST_MODE_DISABLE_BIT] || !write_prot_ff[PASSWORD_OK_BIT_BIT];
endmodule

// ---- nvm_pkg.sv ----
// Package with addresses, field positions and reset values of the flash and emulated EEPROM controller.
// Assumes a 24-bit core address bus with byte-wide data.
package nvm_pkg;
    localparam int ADDR_W = 24;
    localparam logic [23:0] STATUS_SECTOR_ADDR = 24'h224002;
    localparam logic [23:0] STATUS_CAUSE_ADDR = 24'h224003;
    localparam logic [23:0] FLASH_CTRL_ADDR = 24'h224000;
    localparam logic [23:0] EEPROM_CTRL_ADDR = 24'h224001;
    localparam logic [23:0] ACCESS_PROTECT_ADDR = 24'h231ffc;
    localparam logic [23:0] WRITE_PROTECT_ADDR = 24'h231ffd;
    localparam logic [23:0] PASSWORD0_ADDR = 24'h231ffe;
    localparam logic [23:0] PASSWORD1_ADDR = 24'h231fff;
    localparam logic [23:0] TEST_AREA_LO = 24'h230000;
    localparam logic [23:0] TEST_AREA_HI = 24'h231f7f;
    localparam logic [23:0] OTP_HI = 24'h231fff;
    localparam logic [23:0] FLASH_LO = 24'h000000;
    localparam logic [23:0] FLASH_HI = 24'h03ffff;
    localparam logic [23:0] EEPROM_LO = 24'h220000;
    localparam logic [23:0] EEPROM_HI = 24'h2203ff;
    localparam logic [23:0] RAM_LO = 24'h200000;
    localparam logic [23:0] RAM_HI = 24'h201fff;
    localparam logic [7:0] BLANK_BYTE = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] PROTECT_RESET = 8'hff;
    // Bit positions
    localparam int START_BIT = 7;
    localparam int WRITE_ERROR_BIT = 7;
    localparam int ERASE_FAIL_BIT = 7;
    localparam int PROGRAM_FAIL_BIT = 6;
    localparam int SWAP_BIT = 5;
    localparam int FLASH_PAGE_BIT = 6;
    localparam int FLASH_PROT_BIT = 1;
    localparam int EEPROM_PAGE_BIT = 6;
    localparam int FLASH_LOCK_BIT = 6;
    localparam int TEST_LOCK_BIT = 5;
    localparam int EEPROM_LOCK_BIT = 4;
    localparam int EXT_LOCK_BIT = 3;
    localparam int TEST_MODE_DISABLE_BIT = 7;
    localparam int PASSWORD_OK_BIT_BIT = 6;
    localparam int SECTOR_W = 7;
    localparam int PAGE_LSB_W = 4;
    localparam int MAX_PAIRS = 16;
    // Fetch source encoding
    typedef enum logic [2:0] {
        SRC_FLASH, SRC_TEST, SRC_OTP, SRC_EEPROM, SRC_RAM, SRC_EXTERNAL
    } fetch_src_t;
    // Target space encoding
    typedef enum logic [2:0] {
        SP_FLASH, SP_TEST, SP_PROT, SP_EEPROM, SP_RAM, SP_OTHER
    } space_t;
endpackage

// ---- nvm_guard_if.sv ----
// Interface carrying an access and its protection verdict between the top and the guard.
// Assumes one clock; the guard is purely combinational.
`timescale 1ns/10ps
interface nvm_guard_if;
    logic [23:0] addr;
    nvm_pkg::fetch_src_t src;
    logic [7:0] access_prot;
    logic blocked;
    nvm_pkg::space_t space;
    modport top (output addr, output src, output access_prot, input blocked, input space);
    modport guard (input addr, input src, input access_prot, output blocked, output space);
endinterface

// ---- nvm_access_guard.sv ----
// Decodes the operand space and decides if the access protection blocks it.
// Assumes the top supplies the live operand address and fetch source.
`timescale 1ns/10ps
module nvm_access_guard (
    // Access to check
    nvm_guard_if.guard g
);
    import nvm_pkg::*;

    // Address to memory space decode
    function automatic space_t decode(input logic [23:0] a);
        if (a >= TEST_AREA_LO && a <= TEST_AREA_HI) decode = SP_TEST;
        else if (a >= ACCESS_PROTECT_ADDR && a <= OTP_HI) decode = SP_PROT;
        else if (a > TEST_AREA_HI && a <= OTP_HI) decode = SP_TEST;
        else if (a >= EEPROM_LO && a <= EEPROM_HI) decode = SP_EEPROM;
        else if (a >= RAM_LO && a <= RAM_HI) decode = SP_RAM;
        else if (a <= FLASH_HI) decode = SP_FLASH;
        else decode = SP_OTHER;
    endfunction

    assign g.space = decode(g.addr);

    // Per-lock blocking, checked on every access
    always_comb begin
        g.blocked = 1'b0;
        if (!g.access_prot[FLASH_LOCK_BIT] && g.space == SP_FLASH &&
            g.src != SRC_TEST && g.src != SRC_FLASH)
            g.blocked = 1'b1;
        if (!g.access_prot[TEST_LOCK_BIT] && (g.space == SP_TEST || g.space == SP_PROT) &&
            g.src != SRC_TEST && g.src != SRC_OTP)
            g.blocked = 1'b1;
        if (!g.access_prot[EEPROM_LOCK_BIT] && g.space == SP_EEPROM &&
            g.src != SRC_TEST && g.src != SRC_FLASH && g.src != SRC_EEPROM)
            g.blocked = 1'b1;
        if (!g.access_prot[EXT_LOCK_BIT] && g.space != SP_OTHER && g.src == SRC_EXTERNAL)
            g.blocked = 1'b1;
    end
endmodule

// ---- nvm_wsp_checker.sv ----
// Concurrent checks on the ports of the flash and emulated EEPROM status and protection block.
// Assumes one clock domain and an asynchronous active-low reset; bound to every instance of the block.
`timescale 1ns/10ps
module nvm_wsp_checker #(
    parameter int PAIRS = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Core bus
    input wire logic [23:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire nvm_pkg::fetch_src_t fetch_src,
    input wire logic [7:0] bus_rdata,
    // Protection image and macro status
    input wire logic init_load,
    input wire logic [7:0] init_access_prot,
    input wire logic flash_busy,
    input wire logic eeprom_busy,
    // Operation outputs
    input wire logic flash_start,
    input wire logic eeprom_start,
    input wire logic [4:0] pair_count,
    input wire logic [7:0] access_prot
);
    import nvm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Protections, read blanking and start sequencing
    reset_forced_a: assert property (disable iff (1'b0) !nrst |-> access_prot == 8'h00)
        else $error("protections not forced in reset");
    init_image_a: assert property (init_load |=> access_prot == $past(init_access_prot))
        else $error("protection image not loaded");
    flash_busy_blank_a: assert property (bus_rd && flash_busy && bus_addr <= FLASH_HI |=> bus_rdata == 8'hff)
        else $error("busy flash read not blanked");
    eeprom_busy_blank_a: assert property (bus_rd && eeprom_busy && bus_addr >= EEPROM_LO && bus_addr <= EEPROM_HI
        |=> bus_rdata == 8'hff) else $error("busy eeprom read not blanked");
    flash_lock_a: assert property (bus_rd && !access_prot[6] && bus_addr <= FLASH_HI && fetch_src != SRC_FLASH
        && fetch_src != SRC_TEST |=> bus_rdata == 8'hff) else $error("flash lock not honoured");
    eeprom_lock_a: assert property (bus_rd && !access_prot[4] && bus_addr >= EEPROM_LO && bus_addr <= EEPROM_HI
        && (fetch_src == SRC_RAM || fetch_src == SRC_EXTERNAL) |=> bus_rdata == 8'hff)
        else $error("eeprom lock not honoured");
    ext_lock_a: assert property (bus_rd && !access_prot[3] && fetch_src == SRC_EXTERNAL && bus_addr >= RAM_LO
        && bus_addr <= RAM_HI |=> bus_rdata == 8'hff) else $error("external lock not honoured");
    start_cause_a: assert property ($rose(flash_start) |-> $past(bus_wr) && $past(bus_addr) == FLASH_CTRL_ADDR
        && $past(bus_wdata[7])) else $error("flash start without start write");
    start_pulse_a: assert property (flash_start || eeprom_start |=> !flash_start && !eeprom_start)
        else $error("start pulse too long");
    pair_bound_a: assert property (pair_count <= PAIRS) else $error("too many pairs latched");
    read_hold_a: assert property (!bus_rd |=> $stable(bus_rdata)) else $error("read data changed");
endmodule
bind nvm_write_status_protection nvm_wsp_checker #(.PAIRS(PAIRS)) nvm_wsp_checker_inst (.*);

// ---- nvm_macro_model.sv ----
// Behavioural model of the flash and emulated EEPROM macro that runs started operations.
// Assumes start pulses from the block; the bench commands a failure through fault.
`timescale 1ns/10ps
module nvm_macro_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Requests
    input wire logic flash_start,
    input wire logic eeprom_start,
    input wire logic [23:0] bus_addr,
    input wire logic fault,
    // Status and results
    output logic [7:0] array_rdata,
    output logic flash_busy,
    output logic eeprom_busy,
    output logic [5:0] busy_sectors,
    output logic op_done,
    output logic program_fail
);
    logic [3:0] left_ff;
    // Array data follows the low address byte, so a stale value passes for a fresh read only at the same low byte
    assign array_rdata = bus_addr[7:0] ^ 8'h3c;
    // Busy for eight cycles, then a done pulse with an optional program failure
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flash_busy <= 1'b0;
            eeprom_busy <= 1'b0;
            busy_sectors <= 6'h00;
            op_done <= 1'b0;
            program_fail <= 1'b0;
            left_ff <= 4'h0;
        end else begin
            op_done <= 1'b0;
            program_fail <= 1'b0;
            if (flash_start || eeprom_start) begin
                flash_busy <= flash_start;
                eeprom_busy <= eeprom_start;
                busy_sectors <= flash_start ? 6'h01 : 6'h10;
                left_ff <= 4'h8;
            end else if (left_ff == 4'h1) begin
                flash_busy <= 1'b0;
                eeprom_busy <= 1'b0;
                busy_sectors <= 6'h00;
                op_done <= 1'b1;
                program_fail <= fault;
                left_ff <= 4'h0;
            end else if (left_ff != 4'h0) begin
                left_ff <= left_ff - 4'h1;
            end
        end
    end
endmodule

// ---- nvm_write_status_protection_test.sv ----
// Self-checking bench: register reads and writes, operation sequences, locks and error flags.
// Assumes the macro model as far side and the checker bound to the block.
`timescale 1ns/10ps
module nvm_write_status_protection_test;
    import nvm_pkg::*;
    logic clk, nrst, bus_wr, bus_rd, init_load, flash_busy, eeprom_busy, erase_suspend, op_done;
    logic erase_fail, program_fail, overwrite_fail, swap_fail, flash_start, eeprom_start, fault;
    logic skip_old_erase, test_modes_enabled;
    logic [23:0] bus_addr, page_addr;
    logic [7:0] bus_wdata, bus_rdata, array_rdata, init_access_prot, init_write_prot, init_pwd0, init_pwd1;
    logic [7:0] access_prot, write_prot;
    logic [5:0] busy_sectors;
    logic [4:0] pair_count;
    fetch_src_t fetch_src;
    int miscompares = 0;
    int checks_done = 0;
    nvm_write_status_protection #(.PAIRS(16)) nvm_write_status_protection_inst (.*);
    nvm_macro_model nvm_macro_model_inst (.*);
    // Clock at 50 MHz
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task close_out;
        if (miscompares == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] mask);
        checks_done++;
        if ((got & mask) !== (exp & mask)) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 bus_addr = a;
        bus_wdata = d;
        bus_wr = 1'b1;
        @(posedge clk);
        #1 bus_wr = 1'b0;
    endtask
    task rd_chk(input logic [23:0] a, input logic [7:0] exp, input logic [7:0] mask);
        @(posedge clk);
        #1 bus_addr = a;
        bus_rd = 1'b1;
        @(posedge clk);
        #1 bus_rd = 1'b0;
        @(posedge clk);
        #1 chk8(bus_rdata, exp, mask);
    endtask
    // Select, load two pairs on two pages, start, then look while busy and wait for the end
    task run_op(input logic [23:0] ctrl, input logic [23:0] base, input logic flt, input logic [7:0] sect);
        int n;
        fault = flt;
        wr(ctrl, 8'h40);
        wr(base + 24'h30, 8'h11);
        wr(base + 24'h05, 8'h22);
        chk8({3'h0, pair_count}, 8'h02, 8'hff);
        chk8(page_addr[11:4], base[11:4], 8'hff);
        wr(ctrl, 8'hc0);
        @(posedge clk);
        rd_chk(STATUS_SECTOR_ADDR, sect, 8'h7f);
        rd_chk(base, 8'hff, 8'hff);
        n = 0;
        while ((flash_busy !== 1'b0 || eeprom_busy !== 1'b0) && n < 100) begin
            @(posedge clk);
            #1 n++;
        end
        if (n == 100) begin
            miscompares++;
            close_out;
        end
    endtask
    // Main sequence
    initial begin
        nrst = 1'b0;
        {bus_wr, bus_rd, init_load, erase_suspend, erase_fail, overwrite_fail, swap_fail, fault} = 8'h00;
        bus_addr = 24'h000000;
        bus_wdata = 8'h00;
        fetch_src = SRC_RAM;
        init_access_prot = 8'hb7;
        {init_write_prot, init_pwd0, init_pwd1} = {8'hff, 8'hff, 8'hff};
        repeat (20) @(posedge clk);
        #1 chk8(access_prot, 8'h00, 8'hff);
        nrst = 1'b1;
        @(posedge clk);
        #1 init_load = 1'b1;
        @(posedge clk);
        #1 init_load = 1'b0;
        chk8(access_prot, 8'hb7, 8'hff);
        rd_chk(STATUS_SECTOR_ADDR, 8'h00, 8'hff);
        rd_chk(STATUS_CAUSE_ADDR, 8'h00, 8'hff);
        rd_chk(24'h001234, 8'hff, 8'hff);
        rd_chk(24'h220010, 8'h2c, 8'hff);
        fetch_src = SRC_FLASH;
        rd_chk(24'h001234, 8'h08, 8'hff);
        fetch_src = SRC_EXTERNAL;
        rd_chk(24'h200010, 8'hff, 8'hff);
        rd_chk(24'h220010, 8'hff, 8'hff);
        fetch_src = SRC_TEST;
        run_op(FLASH_CTRL_ADDR, 24'h000100, 1'b1, 8'h01);
        rd_chk(STATUS_SECTOR_ADDR, 8'h80, 8'h80);
        rd_chk(STATUS_CAUSE_ADDR, 8'h40, 8'hc0);
        @(posedge clk);
        #1 erase_fail = 1'b1;
        @(posedge clk);
        #1 erase_fail = 1'b0;
        rd_chk(STATUS_CAUSE_ADDR, 8'hc0, 8'he0);
        wr(STATUS_CAUSE_ADDR, 8'h00);
        rd_chk(STATUS_CAUSE_ADDR, 8'hc0, 8'he0);
        wr(STATUS_SECTOR_ADDR, 8'h7f);
        rd_chk(STATUS_CAUSE_ADDR, 8'h00, 8'hff);
        rd_chk(STATUS_SECTOR_ADDR, 8'h00, 8'h80);
        run_op(EEPROM_CTRL_ADDR, 24'h220000, 1'b0, 8'h10);
        rd_chk(STATUS_SECTOR_ADDR, 8'h00, 8'h80);
        wr(EEPROM_CTRL_ADDR, 8'h40);
        wr(24'h220001, 8'h55);
        wr(EEPROM_CTRL_ADDR, 8'h00);
        chk8({3'h0, pair_count}, 8'h00, 8'hff);
        close_out;
    end
endmodule
